// [include/fieldbus_params.svh]
// constants for the fieldbus parameter and process channel interpreter
`ifndef FIELDBUS_PARAMS_SVH
`define FIELDBUS_PARAMS_SVH

`define TASK_NONE 4'h0
`define TASK_READ 4'h1
`define TASK_MODIFY 4'h2
`define RESP_OK 4'h1
`define RESP_ERR 4'h7
`define TASK_HI 15
`define TASK_LO 12
`define TASK_DONTCARE_BIT 11
`define GROUP_HI 7
`define GROUP_LO 0
`define INDEX_HI 15
`define INDEX_LO 8

`define ERR_LOCKED 16'h0001
`define ERR_BAD_CMD 16'h0002
`define ERR_BAD_ADDR 16'h0003
`define ERR_BAD_VALUE 16'h0004
`define ERR_RUNNING 16'h0005
`define ERR_READ_ONLY 16'h0006
`define ERR_NO_EXT_WRITE 16'h0007

`define CMD_INHIBIT_BIT 7
`define CMD_RAMP_HOLD_BIT 6
`define CMD_ERR_RESET_BIT 5
`define CMD_ESTOP_BIT 4
`define CMD_STOP_BIT 3
`define CMD_REVERSE_BIT 2
`define CMD_JOG_BIT 1
`define CMD_RUN_BIT 0

`define NUM_GROUPS 4
`define GROUP_SIZE 16
`define MON_WORDS 8
`define MON_SEL_W 4
`define MON_SRC 16
`define PARAM_RESET 16'h0000
`define LIMIT_RESET 16'hffff

`endif

// [include/fieldbus_pkg.sv]
// types shared by the fieldbus interpreter files
package fieldbus_pkg;
	typedef struct packed {
		logic [15:0] task_word;
		logic [15:0] index_word;
		logic [15:0] value_high;
		logic [15:0] value_low;
	} param_channel_t;

	typedef struct packed {
		logic ramp_hold;
		logic err_reset;
		logic estop;
		logic stop;
		logic reverse;
		logic jog;
		logic run;
	} drive_cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOOKUP = 2'b01,
		ST_ANSWER = 2'b10
	} param_state_t;
endpackage : fieldbus_pkg

// [verilog/param_store.sv]
// parameter store with per-entry limits and access attributes
`timescale 1ns/10ps
`include "fieldbus_params.svh"
module param_store (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] group,
	input wire logic [7:0] index,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	output logic [15:0] rd_data,
	output logic [15:0] upper_limit,
	output logic addr_ok,
	output logic read_only,
	output logic no_ext_write,
	output logic run_locked
);
	localparam int DEPTH = `NUM_GROUPS * `GROUP_SIZE;
	logic [15:0] mem_q [DEPTH];
	logic [15:0] mem_d [DEPTH];
	logic [5:0] addr;

	// flat address and range check
	always_comb begin
		addr_ok = (group < 8'(`NUM_GROUPS)) && (index < 8'(`GROUP_SIZE));
		addr = {group[1:0], index[3:0]};
		rd_data = mem_q[addr];
		upper_limit = `LIMIT_RESET >> index[1:0];
		read_only = (index[3:2] == 2'b11);
		no_ext_write = (index[3:2] == 2'b10);
		run_locked = (index[3:2] == 2'b01);
	end

	// one entry per generate step: next value and register
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		always_comb begin
			mem_d[i] = mem_q[i];
			if (wr_en && (addr == 6'(i))) begin
				mem_d[i] = wr_data;
			end
		end
		always_ff @(posedge clk) begin
			if (!rst_b) begin
				mem_q[i] <= `PARAM_RESET;
			end else begin
				mem_q[i] <= mem_d[i];
			end
		end
	end
endmodule : param_store

// [verilog/monitor_select.sv]
// picks monitoring quantities for the extra response process words
`timescale 1ns/10ps
`include "fieldbus_params.svh"
module monitor_select (
	input wire logic [`MON_WORDS*`MON_SEL_W-1:0] sel,
	input wire logic [`MON_SRC*16-1:0] sources,
	output logic [`MON_WORDS*16-1:0] words
);
	// each word takes the source named by its selector nibble
	always_comb begin
		for (int i = 0; i < `MON_WORDS; i++) begin
			words[i*16 +: 16] = sources[sel[i*`MON_SEL_W +: `MON_SEL_W]*16 +: 16];
		end
	end
endmodule : monitor_select

// [verilog/fieldbus_channel.sv]
// slave-side interpreter of parameter and process channels in each telegram
`timescale 1ns/10ps
`include "fieldbus_params.svh"
// How it works
// - each telegram has its process part interpreted; its parameter part only when idle and the request changed
// - bit 11 of the request task word is ignored
// - read answers task 1, echoes group and index, returns value
// - accepted modify stores the low value word and answers task 1
// - index out of range answers task 7 with cause 3
// - value above the upper limit is not stored; cause 4
// - undefined task nibble does no access; cause 2
// - password lock rejects modify with cause 1
// - running drive rejects modify of run-locked parameter with cause 5
// - modify of read-only parameter is rejected with cause 6
// - modify of parameter without external write rejected with cause 7
// - response carries state word, actual speed, then monitor words
// - command word acted on only when bit 7 is zero
// - command bits are active high: hold, reset, estop, stop, rev, jog, run
// - task nibble 0 none, 1 read, 2 modify, others illegal
// - no-task answers task 0 and zero value, no access
module fieldbus_channel (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic telegram_valid,
	input wire fieldbus_pkg::param_channel_t param_req,
	input wire logic [15:0] drive_command_word,
	input wire logic [15:0] speed_setpoint,
	input wire logic password_lock,
	input wire logic drive_running,
	input wire logic [15:0] drive_state_word,
	input wire logic [15:0] actual_speed_word,
	input wire logic [`MON_WORDS*`MON_SEL_W-1:0] monitor_sel,
	input wire logic [`MON_SRC*16-1:0] monitor_sources,
	output fieldbus_pkg::param_channel_t param_resp,
	output logic [15:0] resp_state_word,
	output logic [15:0] resp_actual_speed,
	output logic [`MON_WORDS*16-1:0] resp_monitor,
	output fieldbus_pkg::drive_cmd_t drive_cmd,
	output logic [15:0] speed_ref,
	output logic cmd_strobe
);
	fieldbus_pkg::param_state_t state_q, state_d;
	fieldbus_pkg::param_channel_t req_q, req_d, resp_q, resp_d;
	logic have_req_q, have_req_d;
	logic [15:0] req_masked;
	logic [15:0] last_task_q, last_task_d;
	logic wr_en;
	logic [15:0] rd_data, upper_limit;
	logic addr_ok, read_only, no_ext_write, run_locked;
	logic [`MON_WORDS*16-1:0] mon_words;
	fieldbus_pkg::drive_cmd_t cmd_q, cmd_d;
	logic [15:0] speed_q, speed_d;
	logic strobe_q, strobe_d;
	logic [15:0] state_word_q, act_q;
	logic [`MON_WORDS*16-1:0] mon_q;

	param_store u_store (
		.clk(clk),
		.rst_b(rst_b),
		.group(req_q.task_word[`GROUP_HI:`GROUP_LO]),
		.index(req_q.index_word[`INDEX_HI:`INDEX_LO]),
		.wr_en(wr_en),
		.wr_data(req_q.value_low),
		.rd_data(rd_data),
		.upper_limit(upper_limit),
		.addr_ok(addr_ok),
		.read_only(read_only),
		.no_ext_write(no_ext_write),
		.run_locked(run_locked)
	);

	monitor_select u_mon (
		.sel(monitor_sel),
		.sources(monitor_sources),
		.words(mon_words)
	);

	// task word with the don't-care bit cleared, so 0x1805 equals 0x1005
	always_comb begin
		req_masked = param_req.task_word;
		req_masked[`TASK_DONTCARE_BIT] = 1'b0;
	end

	// parameter channel: take a new request, look it up, answer
	always_comb begin
		state_d = state_q;
		req_d = req_q;
		resp_d = resp_q;
		have_req_d = have_req_q;
		last_task_d = last_task_q;
		wr_en = 1'b0;
		case (state_q)
			fieldbus_pkg::ST_IDLE: begin
				// only a changed request is executed again
				if (telegram_valid && (!have_req_q || req_masked != last_task_q ||
						param_req.index_word != req_q.index_word ||
						param_req.value_low != req_q.value_low)) begin
					req_d = param_req;
					req_d.task_word = req_masked;
					last_task_d = req_masked;
					have_req_d = 1'b1;
					state_d = fieldbus_pkg::ST_LOOKUP;
				end
			end
			fieldbus_pkg::ST_LOOKUP: begin
				resp_d.task_word = {`RESP_ERR, 4'h0, req_q.task_word[7:0]};
				resp_d.index_word = req_q.index_word;
				resp_d.value_high = 16'h0000;
				case (req_q.task_word[`TASK_HI:`TASK_LO])
					`TASK_NONE: begin
						resp_d.task_word = {`TASK_NONE, 4'h0, req_q.task_word[7:0]};
						resp_d.value_low = 16'h0000;
					end
					`TASK_READ: begin
						if (!addr_ok) begin
							resp_d.value_low = `ERR_BAD_ADDR;
						end else begin
							resp_d.task_word[`TASK_HI:`TASK_LO] = `RESP_OK;
							resp_d.value_low = rd_data;
						end
					end
					`TASK_MODIFY: begin
						if (!addr_ok) begin
							resp_d.value_low = `ERR_BAD_ADDR;
						end else if (password_lock) begin
							resp_d.value_low = `ERR_LOCKED;
						end else if (read_only) begin
							resp_d.value_low = `ERR_READ_ONLY;
						end else if (no_ext_write) begin
							resp_d.value_low = `ERR_NO_EXT_WRITE;
						end else if (drive_running && run_locked) begin
							resp_d.value_low = `ERR_RUNNING;
						end else if (req_q.value_low > upper_limit) begin
							resp_d.value_low = `ERR_BAD_VALUE;
						end else begin
							wr_en = 1'b1;
							resp_d.task_word[`TASK_HI:`TASK_LO] = `RESP_OK;
							resp_d.value_low = req_q.value_low;
						end
					end
					default: begin
						resp_d.value_low = `ERR_BAD_CMD;
					end
				endcase
				state_d = fieldbus_pkg::ST_ANSWER;
			end
			fieldbus_pkg::ST_ANSWER: begin
				state_d = fieldbus_pkg::ST_IDLE;
			end
			default: begin
				state_d = fieldbus_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= fieldbus_pkg::ST_IDLE;
			req_q <= '0;
			resp_q <= '0;
			have_req_q <= 1'b0;
			last_task_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			req_q <= req_d;
			resp_q <= resp_d;
			have_req_q <= have_req_d;
			last_task_q <= last_task_d;
		end
	end

	// process channel: decode command word, ignore it when inhibited
	always_comb begin
		cmd_d = cmd_q;
		speed_d = speed_q;
		strobe_d = 1'b0;
		if (telegram_valid && !drive_command_word[`CMD_INHIBIT_BIT]) begin
			cmd_d.ramp_hold = drive_command_word[`CMD_RAMP_HOLD_BIT];
			cmd_d.err_reset = drive_command_word[`CMD_ERR_RESET_BIT];
			cmd_d.estop = drive_command_word[`CMD_ESTOP_BIT];
			cmd_d.stop = drive_command_word[`CMD_STOP_BIT];
			cmd_d.reverse = drive_command_word[`CMD_REVERSE_BIT];
			cmd_d.jog = drive_command_word[`CMD_JOG_BIT];
			cmd_d.run = drive_command_word[`CMD_RUN_BIT];
			speed_d = speed_setpoint;
			strobe_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cmd_q <= '0;
			speed_q <= 16'h0000;
			strobe_q <= 1'b0;
		end else begin
			cmd_q <= cmd_d;
			speed_q <= speed_d;
			strobe_q <= strobe_d;
		end
	end

	// response process words sampled every cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_word_q <= 16'h0000;
			act_q <= 16'h0000;
			mon_q <= '0;
		end else begin
			state_word_q <= drive_state_word;
			act_q <= actual_speed_word;
			mon_q <= mon_words;
		end
	end

	assign param_resp = resp_q;
	assign resp_state_word = state_word_q;
	assign resp_actual_speed = act_q;
	assign resp_monitor = mon_q;
	assign drive_cmd = cmd_q;
	assign speed_ref = speed_q;
	assign cmd_strobe = strobe_q;
endmodule : fieldbus_channel

// [bench/fieldbus_checker.sv]
// concurrent checks on the fieldbus channel ports
`timescale 1ns/10ps
module fieldbus_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic telegram_valid,
	input wire fieldbus_pkg::param_channel_t param_req,
	input wire logic [15:0] drive_command_word,
	input wire logic [15:0] speed_setpoint,
	input wire logic [15:0] drive_state_word,
	input wire fieldbus_pkg::param_channel_t param_resp,
	input wire logic [15:0] resp_state_word,
	input wire fieldbus_pkg::drive_cmd_t drive_cmd,
	input wire logic [15:0] speed_ref,
	input wire logic cmd_strobe
);
	// task nibbles of request and response
	wire logic [3:0] rq = param_req.task_word[15:12];
	wire logic [3:0] rs = param_resp.task_word[15:12];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// process channel
	property p_take;
		telegram_valid && !drive_command_word[7] |=> cmd_strobe && speed_ref == $past(speed_setpoint)
			&& {9'h000, drive_cmd} == ($past(drive_command_word) & 16'h007f);
	endproperty
	a_take: assert property (p_take) else $error("command not applied");
	property p_skip;
		telegram_valid && drive_command_word[7] |=> !cmd_strobe;
	endproperty
	a_skip: assert property (p_skip) else $error("inhibited command strobed");
	property p_state;
		$past(rst_b) |-> resp_state_word == $past(drive_state_word);
	endproperty
	a_state: assert property (p_state) else $error("state word not returned");
	// parameter channel
	property p_none;
		telegram_valid && rq == 4'h0 |-> ##3 rs == 4'h0 && param_resp.value_low == 16'h0000;
	endproperty
	a_none: assert property (p_none) else $error("no-task answer wrong");
	property p_bad;
		telegram_valid && rq > 4'h2 |-> ##3 rs == 4'h7 && param_resp.value_low == 16'h0002;
	endproperty
	a_bad: assert property (p_bad) else $error("illegal task not refused");
	property p_echo;
		telegram_valid && rq != 4'h0 |-> ##3 param_resp.index_word == $past(param_req.index_word, 3)
			&& param_resp.task_word[11:0] == {4'h0, $past(param_req.task_word[7:0], 3)};
	endproperty
	a_echo: assert property (p_echo) else $error("address not echoed");
	property p_high;
		param_resp.value_high == 16'h0000;
	endproperty
	a_high: assert property (p_high) else $error("high value word not zero");
	property p_stand;
		!$stable(param_resp) |-> $past(telegram_valid, 2) || $past(telegram_valid, 3);
	endproperty
	a_stand: assert property (p_stand) else $error("answer changed unasked");
	c_modify: cover property (telegram_valid && rq == 4'h2);
	c_error: cover property (rs == 4'h7);
	c_inhibit: cover property (telegram_valid && drive_command_word[7]);
endmodule : fieldbus_checker
bind fieldbus_channel fieldbus_checker i_fieldbus_checker (.clk, .rst_b, .telegram_valid,
	.param_req, .drive_command_word, .speed_setpoint, .drive_state_word, .param_resp,
	.resp_state_word, .drive_cmd, .speed_ref, .cmd_strobe);

// [bench/fieldbus_master.sv]
// model of the fieldbus master sending telegrams
`timescale 1ns/10ps
module fieldbus_master (
	input wire logic clk,
	output logic telegram_valid,
	output fieldbus_pkg::param_channel_t param_req,
	output logic [15:0] drive_command_word,
	output logic [15:0] speed_setpoint
);
	// quiet bus before the first telegram
	initial begin
		telegram_valid = 1'b0;
		param_req = '0;
		drive_command_word = 16'h0080;
		speed_setpoint = 16'h0000;
	end
	// one telegram with both channels, valid for one cycle
	task send(input logic [15:0] tw, input logic [15:0] iw, input logic [15:0] vl,
		input logic [15:0] cw, input logic [15:0] sp);
		@(negedge clk);
		telegram_valid = 1'b1;
		param_req = {tw, iw, 16'h0000, vl};
		drive_command_word = cw;
		speed_setpoint = sp;
		@(negedge clk);
		telegram_valid = 1'b0;
		{param_req, drive_command_word, speed_setpoint} = ~{param_req, drive_command_word,
			speed_setpoint}; // stale fields inverted between telegrams
	endtask : send
endmodule : fieldbus_master

// [bench/tb.sv]
// self-checking bench for the fieldbus channel
`timescale 1ns/10ps
module tb;
	logic clk, rst_b, password_lock, drive_running, telegram_valid, cmd_strobe;
	logic [15:0] drive_state_word, actual_speed_word, resp_state_word, resp_actual_speed;
	logic [15:0] drive_command_word, speed_setpoint, speed_ref;
	logic [31:0] monitor_sel;
	logic [255:0] monitor_sources;
	logic [127:0] resp_monitor;
	fieldbus_pkg::param_channel_t param_req, param_resp;
	fieldbus_pkg::drive_cmd_t drive_cmd;
	int miscompares = 0;
	int samples_checked = 0;
	int k;
	fieldbus_master i_fieldbus_master (.clk, .telegram_valid, .param_req, .drive_command_word,
		.speed_setpoint);
	fieldbus_channel i_fieldbus_channel (.clk, .rst_b, .telegram_valid, .param_req,
		.drive_command_word, .speed_setpoint, .password_lock, .drive_running, .drive_state_word,
		.actual_speed_word, .monitor_sel, .monitor_sources, .param_resp, .resp_state_word,
		.resp_actual_speed, .resp_monitor, .drive_cmd, .speed_ref, .cmd_strobe);
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// compare tasks
	task chk_resp(input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask : chk_resp
	task chk_word(input logic [15:0] e, input logic [15:0] g);
		chk_resp({48'h0, e}, {48'h0, g});
	endtask : chk_word
	// parameter request and its answer
	task op(input logic [15:0] tw, input logic [15:0] iw, input logic [15:0] vl,
		input logic [15:0] rt, input logic [15:0] rv);
		i_fieldbus_master.send(tw, iw, vl, 16'h0080, 16'h0000);
		repeat (3) @(negedge clk);
		chk_resp({rt, iw, 16'h0000, rv}, param_resp);
	endtask : op
	// command telegram and the resulting outputs
	task cmd(input logic [15:0] cw, input logic [15:0] sp, input logic [6:0] ed,
		input logic [15:0] er, input logic es);
		i_fieldbus_master.send(16'h0000, 16'h0000, 16'h0000, cw, sp);
		chk_word({15'h0, es}, {15'h0, cmd_strobe});
		chk_word({9'h0, ed}, {9'h0, drive_cmd});
		chk_word(er, speed_ref);
		@(negedge clk);
		chk_word(16'h0000, {15'h0, cmd_strobe});
		repeat (2) @(negedge clk);
	endtask : cmd
	task conclude;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	// watchdog against a hung run
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		conclude();
	end
	// main sequence
	initial begin
		rst_b = 1'b0;
		password_lock = 1'b0;
		drive_running = 1'b0;
		drive_state_word = 16'h0180;
		actual_speed_word = 16'h4e20;
		monitor_sel = 32'h0123_4567;
		for (k = 0; k < 16; k++) monitor_sources[16*k+:16] = 16'h00a0 + 16'(k);
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		chk_word(16'h0180, resp_state_word);
		chk_word(16'h4e20, resp_actual_speed);
		for (k = 0; k < 8; k++) chk_word(16'h00a7 - 16'(k), resp_monitor[16*k+:16]);
		$display("test process words done");
		op(16'h1801, 16'h0000, 16'h0000, 16'h1001, 16'h0000);
		op(16'h2001, 16'h0100, 16'h7fff, 16'h1001, 16'h7fff);
		op(16'h2001, 16'h0100, 16'h8000, 16'h7001, 16'h0004);
		op(16'h1001, 16'h0100, 16'h0000, 16'h1001, 16'h7fff);
		op(16'h1001, 16'h2000, 16'h0000, 16'h7001, 16'h0003);
		op(16'h1004, 16'h0000, 16'h0000, 16'h7004, 16'h0003);
		op(16'h8001, 16'h0100, 16'h0bb8, 16'h7001, 16'h0002);
		op(16'hf001, 16'h0100, 16'h0bb8, 16'h7001, 16'h0002);
		op(16'h1001, 16'h0100, 16'h0000, 16'h1001, 16'h7fff);
		op(16'h2000, 16'h0c00, 16'h0001, 16'h7000, 16'h0006);
		op(16'h2000, 16'h0800, 16'h0001, 16'h7000, 16'h0007);
		password_lock = 1'b1;
		op(16'h2001, 16'h0100, 16'h0bb8, 16'h7001, 16'h0001);
		password_lock = 1'b0;
		drive_running = 1'b1;
		op(16'h2000, 16'h0400, 16'h0001, 16'h7000, 16'h0005);
		op(16'h2000, 16'h0000, 16'h0bb8, 16'h1000, 16'h0bb8);
		drive_running = 1'b0;
		op(16'h0000, 16'h0000, 16'h1234, 16'h0000, 16'h0000);
		$display("test parameter channel done");
		cmd(16'h007f, 16'h1388, 7'h7f, 16'h1388, 1'b1);
		cmd(16'h0081, 16'h4e20, 7'h7f, 16'h1388, 1'b0);
		for (k = 0; k < 7; k++) cmd(16'hff00 | (16'h0001 << k), 16'h0100, 7'h01 << k, 16'h0100, 1'b1);
		$display("test command word done");
		conclude();
	end
endmodule : tb
